// ===== uartp_pkg.sv
// Shared constants and types of the serial port pin and infrared mode control
package uartp_pkg;

  // APB register byte offsets
  localparam logic [7:0] UARTP_MODE_OFS = 8'h00; // Mode control register
  localparam logic [7:0] UARTP_DIV_OFS = 8'h04; // Baud generator divisor
  localparam logic [7:0] UARTP_STAT_OFS = 8'h08; // Pin and codec status, read only

  // Field positions in the mode control register
  localparam int UARTP_EN_BIT = 15; // Port enable
  localparam int UARTP_INFRARED_CODEC_ENABLE_BIT = 12; // Infrared codec enable
  localparam int UARTP_REQUEST_PIN_BEHAVIOUR_SELECT_BIT = 11; // Request pin behaviour select
  localparam int UARTP_USE_HI = 9; // Pin usage field, upper bit
  localparam int UARTP_USE_LO = 8; // Pin usage field, lower bit
  localparam int UARTP_HIGH_SPEED_BAUD_SELECT_BIT = 3; // High speed baud select

  // Reset values and write masks; bits 14 and 10 are unimplemented
  localparam logic [15:0] UARTP_MODE_RST = 16'h0000;
  localparam logic [15:0] UARTP_MODE_WMASK = 16'hBBFF;
  localparam logic [15:0] UARTP_DIV_RST = 16'h0000;

  // Baud generator ticks per serial bit
  localparam logic [4:0] UARTP_TICKS_STD = 5'h10; // Standard mode, 16 ticks
  localparam logic [4:0] UARTP_TICKS_HS = 5'h04; // High speed mode, 4 ticks

  // Infrared pulse shaping, in 16x ticks
  localparam logic [3:0] UARTP_IR_PULSE = 4'h3; // Encoder pulse length, 3/16 bit
  localparam logic [4:0] UARTP_DEC_HOLD = 5'h10; // Decoder holds a zero for one bit

  // Pin usage field codes
  typedef enum logic [1:0] {
    UARTP_USE_TXRX = 2'h0, // Transmit and receive only
    UARTP_USE_RTS = 2'h1, // Plus request to send
    UARTP_USE_FLOW = 2'h2, // Plus request and clear to send
    UARTP_USE_BCLK = 2'h3 // Plus baud clock on the request pin
  } uartp_usage_type;

endpackage

// ===== uartp_ir_if.sv
// Link between the mode control and its infrared codec
`timescale 1ns/1ps
interface uartp_ir_if;
  logic tick; // One-cycle 16x baud tick
  logic bit_start; // One-cycle pulse at each serial bit boundary
  logic enable; // Codec in use
  logic enc_in; // Serial data from the transmitter
  logic enc_out; // Pulse output toward the infrared emitter
  logic dec_in; // Pulse input from the infrared receiver
  logic dec_out; // Rebuilt serial data toward the receiver
  modport codec (input tick, bit_start, enable, enc_in, dec_in, output enc_out, dec_out);
  modport ctrl (output tick, bit_start, enable, enc_in, dec_in, input enc_out, dec_out);
endinterface

// ===== uartp_ir_codec.sv
// Infrared pulse encoder and decoder working on 16x baud ticks
`timescale 1ns/1ps
module uartp_ir_codec
  import uartp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  uartp_ir_if.codec ir
);

  logic [3:0] phase_r; // Tick position inside the current bit
  logic [3:0] phase_nxt;
  logic enc_r; // Encoder output
  logic enc_nxt;
  logic [4:0] hold_r; // Ticks left of a decoded zero
  logic [4:0] hold_nxt;
  logic dec_r; // Decoder output, idles high
  logic dec_nxt;
  logic din_d_r; // Previous receive level for edge finding
  logic din_d_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: a zero bit becomes a short pulse at the start of the bit
  always_comb begin
    phase_nxt = phase_r;
    if (ir.bit_start) begin
      phase_nxt = 4'h0; // Realign to the transmitter's bit grid
    end else if (ir.tick) begin
      phase_nxt = phase_r + 4'h1;
    end
    enc_nxt = ir.enable && !ir.enc_in && (phase_nxt < UARTP_IR_PULSE);
    din_d_nxt = ir.dec_in;
    hold_nxt = hold_r;
    if (!ir.enable) begin
      hold_nxt = 5'h00; // Bypassed: forget any half-seen pulse
    end else if (ir.dec_in && !din_d_r) begin
      hold_nxt = UARTP_DEC_HOLD; // A pulse rebuilds a full zero bit
    end else if (ir.tick && (hold_r != 5'h00)) begin
      hold_nxt = hold_r - 5'h01;
    end
    dec_nxt = (hold_nxt == 5'h00);
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= 4'h0;
      enc_r <= 1'b0;
      hold_r <= 5'h00;
      dec_r <= 1'b1;
      din_d_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      enc_r <= enc_nxt;
      hold_r <= hold_nxt;
      dec_r <= dec_nxt;
      din_d_r <= din_d_nxt;
    end
  end

  assign ir.enc_out = enc_r;
  assign ir.dec_out = dec_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_enc_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
    enc_r |-> (phase_r < UARTP_IR_PULSE) && $past(ir.enable))
    else $error("encoder pulse outside its 3/16 slot");
  a_dec_zero_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ir.enable && ir.dec_in && !din_d_r) |=> !dec_r [*2])
    else $error("received pulse did not give a zero");
  a_enc_bypass_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !ir.enable |=> !enc_r && dec_r)
    else $error("codec active while bypassed");

endmodule

// ===== uartp_mode_ctrl.sv
// Serial port pin ownership, request pin behaviour and infrared mode control
// How it works
// - Codec enable bit 12 routes through infrared
// - Bit 11 set gives simplex, clear flow control
// - Usage 01 owns transmit, receive, request
// - Usage 00 leaves both handshake pins latched
// - Infrared codec works only in 16x mode
// - Usage 11 drives 16x baud clock out
// - Infrared active: pins face the transceiver
// - Bits last 16 or four generator ticks
`timescale 1ns/1ps
module uartp_mode_ctrl
  import uartp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic tx_serial_i, // Serial data from the transmitter
  input wire logic tx_busy_i, // Transmitter has data to send
  input wire logic rx_ready_i, // Receiver can take a character
  output logic rx_serial_o, // Serial data toward the receiver
  output logic tx_clear_o, // Transmitter may send
  output logic bit_tick_o, // One pulse per serial bit
  output logic serial_transmit_pin_o,
  output logic serial_transmit_pin_oe_n_o,
  input wire logic serial_receive_pin_i,
  output logic request_to_send_pin_o,
  output logic request_to_send_pin_oe_n_o,
  input wire logic clear_to_send_pin_i,
  output logic clear_to_send_pin_o,
  output logic clear_to_send_pin_oe_n_o,
  input wire logic latch_tx_i, // Port latch values for pins the port does not own
  input wire logic latch_tx_oe_n_i,
  input wire logic latch_rts_i,
  input wire logic latch_rts_oe_n_i,
  input wire logic latch_cts_i,
  input wire logic latch_cts_oe_n_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding used only by the status word's pin ownership bits
  function automatic logic rts_owned(input logic en, input uartp_usage_type use_f);
    rts_owned = en && (use_f != UARTP_USE_TXRX) && (use_f != UARTP_USE_FLOW + 2'h0)
      || en && (use_f == UARTP_USE_FLOW);
  endfunction

  function automatic logic cts_owned(input logic en, input uartp_usage_type use_f);
    cts_owned = en && (use_f == UARTP_USE_FLOW);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] mode_r; // Mode control register
  logic [15:0] mode_nxt;
  logic [15:0] div_r; // Half-period of the 16x tick, minus one
  logic [15:0] div_nxt;
  logic [31:0] rdata_r; // Read data held for the bus
  logic [31:0] rdata_nxt;
  logic ready_r; // Access phase answer, one wait state
  logic ready_nxt;
  logic err_r; // Unmapped address answer
  logic err_nxt;

  logic en; // Port enabled
  logic infrared_codec_enable; // Infrared codec requested
  logic high_speed_baud_select; // High speed baud select
  logic request_pin_behaviour_select; // Request pin simplex when set
  uartp_usage_type usage; // Pin usage field
  logic ir_on; // Codec really in the path
  logic access; // Access phase seen
  logic wr_go; // Write commits at this edge
  logic hit_mode;
  logic hit_div;
  logic hit_stat;
  logic [31:0] stat_word; // Live status for reads

  assign en = mode_r[UARTP_EN_BIT];
  assign infrared_codec_enable = mode_r[UARTP_INFRARED_CODEC_ENABLE_BIT];
  assign high_speed_baud_select = mode_r[UARTP_HIGH_SPEED_BAUD_SELECT_BIT];
  assign request_pin_behaviour_select = mode_r[UARTP_REQUEST_PIN_BEHAVIOUR_SELECT_BIT];
  assign usage = uartp_usage_type'(mode_r[UARTP_USE_HI:UARTP_USE_LO]);
  // The pulse codec needs sixteen ticks a bit, so high speed mode bypasses it
  assign ir_on = en && infrared_codec_enable && !high_speed_baud_select;
  assign access = psel_i && penable_i;
  assign wr_go = access && ready_r && pwrite_i && !err_r;
  assign hit_mode = (paddr_i == UARTP_MODE_OFS);
  assign hit_div = (paddr_i == UARTP_DIV_OFS);
  assign hit_stat = (paddr_i == UARTP_STAT_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: answer one cycle into the access phase, write at that edge
  always_comb begin
    mode_nxt = mode_r;
    div_nxt = div_r;
    ready_nxt = 1'b0;
    err_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (access && !ready_r) begin
      ready_nxt = 1'b1;
      err_nxt = !(hit_mode || hit_div || hit_stat);
      if (hit_mode) begin
        rdata_nxt = {16'h0000, mode_r};
      end else if (hit_div) begin
        rdata_nxt = {16'h0000, div_r};
      end else if (hit_stat) begin
        rdata_nxt = stat_word;
      end else begin
        rdata_nxt = 32'h0000_0000; // Unmapped reads return zero
      end
    end
    if (wr_go && hit_mode) begin
      mode_nxt = pwdata_i[15:0] & UARTP_MODE_WMASK;
    end
    if (wr_go && hit_div) begin
      div_nxt = pwdata_i[15:0];
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= UARTP_MODE_RST;
      div_r <= UARTP_DIV_RST;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: half-tick counter, 16x tick, bit counter
  logic [15:0] cnt_r; // Cycles within a half tick
  logic [15:0] cnt_nxt;
  logic half_r; // Second half of a 16x tick
  logic half_nxt;
  logic bclk_r; // 16x clock level, toggles every half tick
  logic bclk_nxt;
  logic [4:0] bitc_r; // 16x ticks within the bit
  logic [4:0] bitc_nxt;
  logic tick16; // One-cycle 16x tick
  logic bit_end; // Last tick of a bit
  logic [4:0] bit_len; // Ticks per bit in the present mode

  assign bit_len = high_speed_baud_select ? UARTP_TICKS_HS : UARTP_TICKS_STD;

  always_comb begin
    cnt_nxt = cnt_r + 16'h0001;
    half_nxt = half_r;
    bclk_nxt = bclk_r;
    bitc_nxt = bitc_r;
    tick16 = 1'b0;
    bit_end = 1'b0;
    if (!en) begin
      // Disabled: hold the generator so it starts clean on enable
      cnt_nxt = 16'h0000;
      half_nxt = 1'b0;
      bclk_nxt = 1'b0;
      bitc_nxt = 5'h00;
    end else if (cnt_r >= div_r) begin
      cnt_nxt = 16'h0000;
      half_nxt = !half_r;
      bclk_nxt = !bclk_r;
      tick16 = half_r;
      if (half_r) begin
        // A shortened count after a mode change restarts the bit at once
        if (bitc_r >= bit_len - 5'h01) begin
          bitc_nxt = 5'h00;
          bit_end = 1'b1;
        end else begin
          bitc_nxt = bitc_r + 5'h01;
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0000;
      half_r <= 1'b0;
      bclk_r <= 1'b0;
      bitc_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
      half_r <= half_nxt;
      bclk_r <= bclk_nxt;
      bitc_r <= bitc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Infrared codec
  uartp_ir_if ir_link ();

  assign ir_link.tick = tick16;
  assign ir_link.bit_start = bit_end;
  assign ir_link.enable = ir_on;
  assign ir_link.enc_in = tx_serial_i;
  assign ir_link.dec_in = serial_receive_pin_i;

  uartp_ir_codec u_codec (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ir (ir_link.codec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership; handshake pins are active low
  logic tx_nxt, tx_oe_nxt, rts_nxt, rts_oe_nxt, cts_nxt, cts_oe_nxt;
  logic rx_nxt, clear_nxt;
  logic tx_r, tx_oe_r, rts_r, rts_oe_r, cts_r, cts_oe_r, rx_r, clear_r, bitt_r;
  logic rts_level; // Request level in the chosen behaviour

  // Simplex asks to send; flow control says the receiver has room
  assign rts_level = request_pin_behaviour_select ? !tx_busy_i : !rx_ready_i;

  always_comb begin
    tx_nxt = latch_tx_i;
    tx_oe_nxt = latch_tx_oe_n_i;
    rts_nxt = latch_rts_i;
    rts_oe_nxt = latch_rts_oe_n_i;
    cts_nxt = latch_cts_i;
    cts_oe_nxt = latch_cts_oe_n_i;
    rx_nxt = ir_on ? ir_link.dec_out : serial_receive_pin_i;
    clear_nxt = 1'b1;
    if (en) begin
      tx_nxt = ir_on ? ir_link.enc_out : tx_serial_i;
      tx_oe_nxt = 1'b0;
      case (usage)
        UARTP_USE_TXRX: begin
          rts_oe_nxt = latch_rts_oe_n_i;
        end
        UARTP_USE_RTS: begin
          rts_nxt = rts_level;
          rts_oe_nxt = 1'b0;
        end
        UARTP_USE_FLOW: begin
          rts_nxt = rts_level;
          rts_oe_nxt = 1'b0;
          cts_nxt = 1'b0;
          cts_oe_nxt = 1'b1; // Pin is an input here
          clear_nxt = !clear_to_send_pin_i;
        end
        UARTP_USE_BCLK: begin
          rts_nxt = bclk_r;
          rts_oe_nxt = 1'b0;
        end
        default: begin
          rts_oe_nxt = latch_rts_oe_n_i;
        end
      endcase
    end
  end

  // Registers only; every port output except the bus answer leaves from here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_r <= 1'b1;
      tx_oe_r <= 1'b1;
      rts_r <= 1'b1;
      rts_oe_r <= 1'b1;
      cts_r <= 1'b1;
      cts_oe_r <= 1'b1;
      rx_r <= 1'b1;
      clear_r <= 1'b1;
      bitt_r <= 1'b0;
    end else begin
      tx_r <= tx_nxt;
      tx_oe_r <= tx_oe_nxt;
      rts_r <= rts_nxt;
      rts_oe_r <= rts_oe_nxt;
      cts_r <= cts_nxt;
      cts_oe_r <= cts_oe_nxt;
      rx_r <= rx_nxt;
      clear_r <= clear_nxt;
      bitt_r <= bit_end;
    end
  end

  assign stat_word = {26'h0000000, usage, rts_owned(en, usage), cts_owned(en, usage),
    bclk_r, ir_on};
  assign prdata_o = rdata_r;
  assign pready_o = ready_r;
  assign pslverr_o = err_r;
  assign serial_transmit_pin_o = tx_r;
  assign serial_transmit_pin_oe_n_o = tx_oe_r;
  assign request_to_send_pin_o = rts_r;
  assign request_to_send_pin_oe_n_o = rts_oe_r;
  assign clear_to_send_pin_o = cts_r;
  assign clear_to_send_pin_oe_n_o = cts_oe_r;
  assign rx_serial_o = rx_r;
  assign tx_clear_o = clear_r;
  assign bit_tick_o = bitt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Check helpers: clock cycles between bit pulses under a steady setup
  logic [23:0] gap_r;
  logic seen_r;
  logic [23:0] gap_want;

  assign gap_want = 24'(bit_len) * 24'h000002 * (24'(div_r) + 24'h000001);

  always_ff @(posedge clk_i) begin
    if (rst_i || !en || wr_go) begin
      gap_r <= 24'h000000;
      seen_r <= 1'b0;
    end else if (bit_tick_o) begin
      gap_r <= 24'h000000;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ir_tx_route: assert property (@(posedge clk_i) disable iff (rst_i)
    ir_on |=> serial_transmit_pin_o == $past(ir_link.enc_out) && !serial_transmit_pin_oe_n_o)
    else $error("transmit pin not fed by the encoder");
  a_ir_bypass_path: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && !infrared_codec_enable) |=> serial_transmit_pin_o == $past(tx_serial_i)
      && rx_serial_o == $past(serial_receive_pin_i))
    else $error("bypassed path altered data");
  a_ir_fast_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && infrared_codec_enable && high_speed_baud_select) |=> rx_serial_o == $past(serial_receive_pin_i)
      && serial_transmit_pin_o == $past(tx_serial_i))
    else $error("codec used in high speed mode");
  a_rts_simplex: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && usage == UARTP_USE_RTS && request_pin_behaviour_select) |=> request_to_send_pin_o == !$past(tx_busy_i)
      && !request_to_send_pin_oe_n_o)
    else $error("simplex request level wrong");
  a_rts_flow: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && usage != UARTP_USE_TXRX && usage != UARTP_USE_BCLK && !request_pin_behaviour_select)
      |=> request_to_send_pin_o == !$past(rx_ready_i))
    else $error("flow control request level wrong");
  a_latch_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && usage == UARTP_USE_TXRX) |=> request_to_send_pin_o == $past(latch_rts_i)
      && clear_to_send_pin_o == $past(latch_cts_i) && tx_clear_o)
    else $error("latched pins taken by the port");
  a_bclk_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && usage == UARTP_USE_BCLK) |=> request_to_send_pin_o == $past(bclk_r)
      && !request_to_send_pin_oe_n_o)
    else $error("baud clock missing on request pin");
  a_bit_period: assert property (@(posedge clk_i) disable iff (rst_i)
    (bit_tick_o && seen_r && en && !wr_go) |-> gap_r == gap_want - 24'h000001)
    else $error("bit length not 16 or 4 ticks");
  a_cts_flow: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && usage == UARTP_USE_FLOW) |=> tx_clear_o == !$past(clear_to_send_pin_i)
      && clear_to_send_pin_oe_n_o)
    else $error("clear to send not honoured");

endmodule

// ===== uartp_far_end.sv
// Far-end model: remote serial equipment or an infrared transceiver
`timescale 1ns/1ps
module uartp_far_end (
  input wire logic clk_i,
  input wire logic line_i, // Level, or light present, that the far side puts on receive
  input wire logic cts_i, // Far side clear-to-send level, active low
  input wire logic tx_pin_i, // Port transmit pin as seen by the far side
  output logic rx_pin_o, // Receive pin of the port
  output logic cts_pin_o, // Clear-to-send pin of the port
  output logic [7:0] pulse_w_o // Length in cycles of the last high pulse on transmit
);
  logic [7:0] run_r = 8'h00; // Cycles the transmit pin has been high so far

  // Idle line levels before the first edge
  initial begin
    rx_pin_o = 1'h1;
    cts_pin_o = 1'h1;
    pulse_w_o = 8'h00;
  end

  // Far side drives its lines just after an edge, like a real registered driver
  always @(posedge clk_i) begin
    rx_pin_o <= line_i;
    cts_pin_o <= cts_i;
  end

  // Emitter pulse meter; an unknown level never counts as light
  always @(posedge clk_i) begin
    if (tx_pin_i === 1'h1) begin
      run_r <= run_r + 8'h01;
    end else begin
      if (run_r != 8'h00) begin
        pulse_w_o <= run_r;
      end
      run_r <= 8'h00;
    end
  end
endmodule

// ===== tb_uart_pin_and_infrared_mode_control.sv
// Self-checking bench for the serial port pin and infrared mode control
`timescale 1ns/1ps
module tb_uart_pin_and_infrared_mode_control;
  import uartp_pkg::*;
  logic clk_i = 1'h0; // 20 MHz clock
  logic rst_i = 1'h1; // Synchronous reset
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // Bus request
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_o;
  logic pready_o, pslverr_o, rx_serial_o, tx_clear_o, bit_tick_o;
  logic tx_serial = 1'h1, tx_busy = 1'h0, rx_ready = 1'h1; // Transmitter and receiver side
  logic line = 1'h1, cts_drv = 1'h1; // Far side commands
  // Latches: tx, tx_oe_n, rts, rts_oe_n, cts, cts_oe_n; tx, rts and cts_oe_n unlike the reset levels
  logic [5:0] lat = 6'h16;
  logic tx_pin, tx_oe_n, rx_pin, rts_pin, rts_oe_n, cts_pin, cts_o, cts_oe_n;
  logic [7:0] pulse_w;
  logic [31:0] rd; // Last read data
  logic er; // Last error response
  int n_mismatch = 0, n_compared = 0;
  int n;

  uartp_mode_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_serial_i(tx_serial), .tx_busy_i(tx_busy),
    .rx_ready_i(rx_ready), .rx_serial_o(rx_serial_o), .tx_clear_o(tx_clear_o),
    .bit_tick_o(bit_tick_o), .serial_transmit_pin_o(tx_pin),
    .serial_transmit_pin_oe_n_o(tx_oe_n), .serial_receive_pin_i(rx_pin),
    .request_to_send_pin_o(rts_pin), .request_to_send_pin_oe_n_o(rts_oe_n),
    .clear_to_send_pin_i(cts_pin), .clear_to_send_pin_o(cts_o),
    .clear_to_send_pin_oe_n_o(cts_oe_n), .latch_tx_i(lat[5]), .latch_tx_oe_n_i(lat[4]),
    .latch_rts_i(lat[3]), .latch_rts_oe_n_i(lat[2]), .latch_cts_i(lat[1]),
    .latch_cts_oe_n_i(lat[0]));

  uartp_far_end far (.clk_i(clk_i), .line_i(line), .cts_i(cts_drv), .tx_pin_i(tx_pin),
    .rx_pin_o(rx_pin), .cts_pin_o(cts_pin), .pulse_w_o(pulse_w));

  always #25 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'h1 && k < 50);
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 50) begin
      n_mismatch++;
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // Mode word from its fields
  function automatic logic [15:0] md(input logic en, ir, sm, input logic [1:0] u,
      input logic bh);
    return {en, 2'h0, ir, sm, 1'h0, u, 4'h0, bh, 3'h0};
  endfunction

  // Cycles between two rising edges of the tick (0) or the request pin (1)
  task automatic period(input int s, output int p);
    logic c, q;
    int first;
    first = -1;
    p = -1;
    q = 1'h1;
    for (int k = 0; k < 400 && p < 0; k++) begin
      @(posedge clk_i);
      c = (s == 0) ? bit_tick_o : rts_pin;
      if (c === 1'h1 && q === 1'h0) begin
        if (first < 0) first = k;
        else p = k - first;
      end
      q = c;
    end
  endtask

  task automatic results;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Tests

  initial begin
    wt(5);
    rst_i <= 1'h0;
    wt(1);
    chk({rts_pin, tx_pin, tx_oe_n, bit_tick_o}, 32'hE);
    apb(1'h0, UARTP_MODE_OFS, 32'h0); chk(rd, 32'h0);
    // Unimplemented mode bits read as zero
    apb(1'h1, UARTP_MODE_OFS, 32'hFFFF);
    apb(1'h0, UARTP_MODE_OFS, 32'h0); chk(rd, 32'hBBFF);
    apb(1'h1, UARTP_MODE_OFS, 32'h0);
    apb(1'h1, UARTP_DIV_OFS, 32'h1);
    apb(1'h0, UARTP_DIV_OFS, 32'h0); chk(rd, 32'h1);
    // Status is read only; an unmapped word answers with an error
    apb(1'h1, UARTP_STAT_OFS, 32'h3F);
    apb(1'h0, UARTP_STAT_OFS, 32'h0); chk(rd, 32'h0);
    apb(1'h0, 8'h0C, 32'h0); chk(rd, 32'h0); chk(er, 32'h1);
    // Pin usage codes, each with both request pin behaviours
    tx_busy <= 1'h1;
    rx_ready <= 1'h0;
    for (int u = 0; u < 4; u++) begin
      for (int s = 0; s < 2; s++) begin
        apb(1'h1, UARTP_MODE_OFS, {16'h0, md(1'h1, 1'h0, s[0], u[1:0], 1'h0)});
        wt(4);
        apb(1'h0, UARTP_STAT_OFS, 32'h0);
        chk(rd & 32'h3D, {26'h0, u[1:0], (u != 0), (u == 2), 2'h0});
        if (u == 0) begin
          chk({rts_pin, rts_oe_n, cts_oe_n, tx_oe_n}, 32'h4);
          chk(cts_o, {31'h0, lat[1]});
        end else if (u < 3) begin
          // Busy transmitter but full receiver: the two behaviours differ
          chk({rts_pin, rts_oe_n}, {30'h0, ~s[0], 1'h0});
          chk(tx_oe_n, 32'h0);
          if (u == 1) begin
            chk(cts_oe_n, 32'h0);
          end else begin
            chk(cts_oe_n, 32'h1);
            cts_drv <= 1'h0;
            wt(4);
            chk(tx_clear_o, 32'h1);
            cts_drv <= 1'h1;
            wt(4);
            chk(tx_clear_o, 32'h0);
          end
        end else begin
          // Divisor 1 gives a 16x tick every four cycles
          period(1, n); chk(n, 32'h4);
        end
      end
    end
    // Bit length in both baud modes
    apb(1'h1, UARTP_MODE_OFS, {16'h0, md(1'h1, 1'h0, 1'h0, 2'h0, 1'h0)});
    period(0, n); chk(n, 32'h40);
    apb(1'h1, UARTP_MODE_OFS, {16'h0, md(1'h1, 1'h0, 1'h0, 2'h0, 1'h1)});
    period(0, n); chk(n, 32'h10);
    // Infrared codec: zero bits become short pulses of three ticks
    line <= 1'h0;
    tx_serial <= 1'h0;
    apb(1'h1, UARTP_MODE_OFS, {16'h0, md(1'h1, 1'h1, 1'h0, 2'h0, 1'h0)});
    wt(150);
    chk(pulse_w, 32'hC);
    apb(1'h0, UARTP_STAT_OFS, 32'h0); chk(rd & 32'h1, 32'h1);
    tx_serial <= 1'h1;
    wt(80);
    chk(tx_pin, 32'h0);
    // A flash on the receiver reads as a zero bit
    line <= 1'h1;
    wt(4);
    line <= 1'h0;
    wt(12);
    chk(rx_serial_o, 32'h0);
    wt(100);
    chk(rx_serial_o, 32'h1);
    // High speed baud mode bypasses the codec even with it enabled
    apb(1'h1, UARTP_MODE_OFS, {16'h0, md(1'h1, 1'h1, 1'h0, 2'h0, 1'h1)});
    apb(1'h0, UARTP_STAT_OFS, 32'h0); chk(rd & 32'h1, 32'h0);
    tx_serial <= 1'h0;
    wt(4);
    chk(tx_pin, 32'h0);
    tx_serial <= 1'h1;
    wt(4);
    chk(tx_pin, 32'h1);
    // Codec off: receive passes straight through
    apb(1'h1, UARTP_MODE_OFS, {16'h0, md(1'h1, 1'h0, 1'h0, 2'h0, 1'h0)});
    wt(4);
    chk(rx_serial_o, 32'h0);
    line <= 1'h1;
    wt(4);
    chk(rx_serial_o, 32'h1);
    results;
  end

  // Watchdog, well beyond the several hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    results;
  end
endmodule
